// file: design/aon_regs_pkg.sv
// Package with offsets, field positions and reset values of the always-on bank
package aon_regs_pkg;

    // Register byte offsets within the bank
    localparam logic [3:0] OFF_POWER_GATING  = 4'h0;
    localparam logic [3:0] OFF_PERIPH_ENABLE = 4'h1;
    localparam logic [3:0] OFF_FAULT_STATUS  = 4'h2;
    localparam logic [3:0] OFF_GPIO_DIR      = 4'h3;
    localparam logic [3:0] OFF_GPIO_POL      = 4'h4;
    localparam logic [3:0] OFF_GPIO_OUT      = 4'h5;
    localparam logic [3:0] OFF_GPIO_IN       = 4'h6;

    // Writable bit masks; all other bits are reserved
    localparam logic [7:0] MASK_POWER_GATING  = 8'h07;
    localparam logic [7:0] MASK_PERIPH_ENABLE = 8'h5F;

    // Field positions, power gating control
    localparam int BIT_CARD_ONE_OFF  = 0;
    localparam int BIT_PULLUP_KEEP   = 1;
    localparam int BIT_CARD_TWO_OFF  = 2;
    // Field positions, peripheral enable control
    localparam int BIT_ONBOARD_DIS   = 0;
    localparam int BIT_PADDLE01_DIS  = 1;
    localparam int BIT_PADDLE24_DIS  = 2;
    localparam int BIT_ID_CONTROL    = 3;
    localparam int BIT_LAN_ZERO_DIS  = 4;
    localparam int BIT_WIRELESS_DIS  = 6;
    // Field positions, fault status and soft reset
    localparam int BIT_SOFT_RESET    = 2;
    localparam int BIT_PADDLE_OC_LO  = 3;
    localparam int BIT_PADDLE_OC_HI  = 5;
    localparam int BIT_PANEL_OC      = 6;
    localparam int BIT_THERMAL       = 7;

    // Reset values
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_GPIO    = 8'h00;

    // Soft reset pulse length in cycles
    localparam int SOFT_RESET_CYCLES = 16;

endpackage : aon_regs_pkg

// file: design/gpio_cfg_if.sv
// Interface carrying the auxiliary GPIO configuration to the pin stage
interface gpio_cfg_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] pol;
    logic [WIDTH-1:0] out_val;
    logic [WIDTH-1:0] pin_in;
    logic [WIDTH-1:0] pin_state;
    modport regs (output dir, output pol, output out_val, input pin_state);
    modport pins (input dir, input pol, input out_val, input pin_in,
                  output pin_state);
endinterface : gpio_cfg_if

// file: design/gpio_pin_stage.sv
// Pin stage for the auxiliary GPIO lines: drive, enable and readback
module gpio_pin_stage #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_sys,   // System clock
    input  wire logic             sys_rst,   // Synchronous reset
    gpio_cfg_if.pins              cfg,       // Configuration carrier
    output logic      [WIDTH-1:0] pin_out,   // Pin output levels
    output logic      [WIDTH-1:0] pin_oe_n   // Pin output enables, low drives
);

    // Elaboration-time refusal of widths the bank cannot serve
    if (WIDTH < 1 || WIDTH > 8)
    begin : g_width_bad
        $error("gpio_pin_stage: WIDTH must be 1 to 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-line drive level and enable registers
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_line
            always_ff @(posedge clk_sys)
            begin
                if (sys_rst)
                begin
                    pin_out[i]  <= 1'b0;
                    pin_oe_n[i] <= 1'b1;
                end
                else
                begin
                    pin_out[i]  <= cfg.out_val[i] ^ cfg.pol[i];
                    pin_oe_n[i] <= ~cfg.dir[i];
                end
            end
        end
    endgenerate

    // Readback of raw pin level regardless of direction or polarity
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            cfg.pin_state <= '0;
        else
            cfg.pin_state <= cfg.pin_in;
    end

endmodule // gpio_pin_stage

// file: design/aon_misc_regs.sv
// Always-on miscellaneous control registers and auxiliary GPIO configuration
module aon_misc_regs #(
    parameter int GPIO_WIDTH = 8
) (
    input  wire logic        clk_sys,            // System clock
    input  wire logic        sys_rst,            // Power-on reset, sync
    input  wire logic        plat_rst,           // Platform reset, sync
    input  wire logic        reg_wr,             // Register write strobe
    input  wire logic        reg_rd,             // Register read strobe
    input  wire logic [3:0]  reg_addr,           // Register byte offset
    input  wire logic [7:0]  reg_wdata,          // Write data
    output logic      [7:0]  reg_rdata,          // Read data
    input  wire logic        s0_power,           // S0 power control signal
    input  wire logic        wireless_ext,       // Other wireless-off sources
    input  wire logic        usb_id_a_cable,     // High when A cable present
    input  wire logic        cpu_thermal_trip,   // Thermal trip from CPU
    input  wire logic        panel_overcurrent,  // Panel switch fault
    input  wire logic        paddle_overcurrent, // Paddle switch fault
    output logic             card_one_power_en,  // Card one 3.3 V enable
    output logic             card_two_power_en,  // Card two 3.3 V enable
    output logic             pullup_power_keep_signal, // Pull-up supply on
    output logic             wireless_disable,   // Wireless disable out
    output logic             lan_off_input_n,    // LAN zero off, low off
    output logic             onboard_vbus_en,    // Onboard VBUS enable
    output logic             paddle01_vbus_en_n, // Ports 0/1 enable, low on
    output logic             paddle24_vbus_en_n, // Ports 2/4 enable, low on
    output logic             onboard_vbus_dis,   // Onboard switch disable
    output logic             soft_button_reset,  // Push-button reset pulse
    input  wire logic [7:0]  gpio_pin_in,        // GPIO pin levels
    output logic      [7:0]  gpio_pin_out,       // GPIO drive levels
    output logic      [7:0]  gpio_pin_oe_n       // GPIO enables, low drives
);

    // Elaboration-time refusal: the byte registers serve eight lines only
    if (GPIO_WIDTH != 8)
    begin : g_width_bad
        $error("aon_misc_regs: GPIO_WIDTH must be 8");
    end

    logic [7:0] power_gating_control_reg;
    logic [7:0] peripheral_enable_control_reg;
    logic [7:0] gpio_direction_reg;
    logic [7:0] gpio_polarity_reg;
    logic [7:0] gpio_output_value_reg;
    logic [4:0] soft_cnt_reg;
    logic       soft_active_reg;
    logic       gpio_rst;
    logic       wr_soft;

    gpio_cfg_if #(.WIDTH(8)) cfg ();

    ////////////////////////////////////////////////////////////////////////
    // Always-on control registers, power-on reset only
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            power_gating_control_reg      <= aon_regs_pkg::RST_CONTROL;
            peripheral_enable_control_reg <= aon_regs_pkg::RST_CONTROL;
        end
        else if (reg_wr)
        begin
            if (reg_addr == aon_regs_pkg::OFF_POWER_GATING)
                power_gating_control_reg <= reg_wdata &
                    aon_regs_pkg::MASK_POWER_GATING;
            if (reg_addr == aon_regs_pkg::OFF_PERIPH_ENABLE)
                peripheral_enable_control_reg <= reg_wdata &
                    aon_regs_pkg::MASK_PERIPH_ENABLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // GPIO configuration, platform reset gated by the keep bit
    assign gpio_rst = sys_rst | (plat_rst &
        ~power_gating_control_reg[aon_regs_pkg::BIT_PULLUP_KEEP]);

    always_ff @(posedge clk_sys)
    begin
        if (gpio_rst)
        begin
            gpio_direction_reg    <= aon_regs_pkg::RST_GPIO;
            gpio_polarity_reg     <= aon_regs_pkg::RST_GPIO;
            gpio_output_value_reg <= aon_regs_pkg::RST_GPIO;
        end
        else if (reg_wr)
        begin
            if (reg_addr == aon_regs_pkg::OFF_GPIO_DIR)
                gpio_direction_reg <= reg_wdata;
            if (reg_addr == aon_regs_pkg::OFF_GPIO_POL)
                gpio_polarity_reg <= reg_wdata;
            if (reg_addr == aon_regs_pkg::OFF_GPIO_OUT)
                gpio_output_value_reg <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Soft push-button reset pulse, cleared by the reset it causes
    assign wr_soft = reg_wr && (reg_addr == aon_regs_pkg::OFF_FAULT_STATUS)
        && reg_wdata[aon_regs_pkg::BIT_SOFT_RESET];

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || plat_rst)
        begin
            soft_active_reg <= 1'b0;
            soft_cnt_reg    <= 5'h00;
        end
        else if (wr_soft)
        begin
            soft_active_reg <= 1'b1;
            soft_cnt_reg    <= 5'(aon_regs_pkg::SOFT_RESET_CYCLES - 1);
        end
        else if (soft_active_reg)
        begin
            if (soft_cnt_reg == 5'h00)
                soft_active_reg <= 1'b0;
            else
                soft_cnt_reg <= soft_cnt_reg - 5'h01;
        end
    end

    assign soft_button_reset = soft_active_reg;

    ////////////////////////////////////////////////////////////////////////
    // Board control outputs
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            card_one_power_en        <= 1'b1;
            card_two_power_en        <= 1'b1;
            pullup_power_keep_signal <= 1'b0;
            wireless_disable         <= 1'b0;
            lan_off_input_n          <= 1'b1;
            onboard_vbus_en          <= 1'b0;
            paddle01_vbus_en_n       <= 1'b0;
            paddle24_vbus_en_n       <= 1'b0;
            onboard_vbus_dis         <= 1'b0;
        end
        else
        begin
            card_one_power_en <= s0_power |
                ~power_gating_control_reg[aon_regs_pkg::BIT_CARD_ONE_OFF];
            card_two_power_en <= s0_power |
                ~power_gating_control_reg[aon_regs_pkg::BIT_CARD_TWO_OFF];
            pullup_power_keep_signal <= s0_power |
                power_gating_control_reg[aon_regs_pkg::BIT_PULLUP_KEEP];
            wireless_disable <= wireless_ext |
                peripheral_enable_control_reg[aon_regs_pkg::BIT_WIRELESS_DIS];
            lan_off_input_n <=
                ~peripheral_enable_control_reg[aon_regs_pkg::BIT_LAN_ZERO_DIS];
            onboard_vbus_en <=
                ~peripheral_enable_control_reg[aon_regs_pkg::BIT_ONBOARD_DIS] &
                (~peripheral_enable_control_reg[aon_regs_pkg::BIT_ID_CONTROL] |
                 usb_id_a_cable);
            paddle24_vbus_en_n <=
                peripheral_enable_control_reg[aon_regs_pkg::BIT_PADDLE24_DIS];
            paddle01_vbus_en_n <=
                peripheral_enable_control_reg[aon_regs_pkg::BIT_PADDLE01_DIS];
            onboard_vbus_dis <=
                peripheral_enable_control_reg[aon_regs_pkg::BIT_ONBOARD_DIS];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin stage
    assign cfg.dir     = gpio_direction_reg;
    assign cfg.pol     = gpio_polarity_reg;
    assign cfg.out_val = gpio_output_value_reg;
    assign cfg.pin_in  = gpio_pin_in;

    gpio_pin_stage #(.WIDTH(8)) u_pins (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .cfg      (cfg),
        .pin_out  (gpio_pin_out),
        .pin_oe_n (gpio_pin_oe_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registered read data; unmapped offsets read zero
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                aon_regs_pkg::OFF_POWER_GATING:
                    reg_rdata <= power_gating_control_reg;
                aon_regs_pkg::OFF_PERIPH_ENABLE:
                    reg_rdata <= peripheral_enable_control_reg;
                aon_regs_pkg::OFF_FAULT_STATUS:
                    reg_rdata <= {cpu_thermal_trip,
                                  panel_overcurrent,
                                  {3{paddle_overcurrent}},
                                  soft_active_reg, 2'b00};
                aon_regs_pkg::OFF_GPIO_DIR:
                    reg_rdata <= gpio_direction_reg;
                aon_regs_pkg::OFF_GPIO_POL:
                    reg_rdata <= gpio_polarity_reg;
                aon_regs_pkg::OFF_GPIO_OUT:
                    reg_rdata <= gpio_output_value_reg;
                aon_regs_pkg::OFF_GPIO_IN:
                    reg_rdata <= cfg.pin_state;
                default:
                    reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule // aon_misc_regs

// file: verification/aon_misc_regs_checker.sv
// Port-level assertions for the always-on register bank
module aon_misc_regs_checker (
    input wire logic       clk_sys,            // System clock
    input wire logic       sys_rst,            // Power-on reset
    input wire logic       plat_rst,           // Platform reset
    input wire logic       reg_wr,             // Write strobe
    input wire logic       reg_rd,             // Read strobe
    input wire logic [3:0] reg_addr,           // Byte offset
    input wire logic [7:0] reg_wdata,          // Write data
    input wire logic [7:0] reg_rdata,          // Read data
    input wire logic       s0_power,           // S0 control
    input wire logic       wireless_ext,       // Other wireless sources
    input wire logic       usb_id_a_cable,     // A cable present
    input wire logic       cpu_thermal_trip,   // Thermal trip
    input wire logic       panel_overcurrent,  // Panel fault
    input wire logic       paddle_overcurrent, // Paddle fault
    input wire logic       card_one_power_en,  // Card one enable
    input wire logic       pullup_power_keep_signal, // Pull-up supply
    input wire logic       wireless_disable,   // Wireless off
    input wire logic       lan_off_input_n,    // LAN off, low off
    input wire logic       onboard_vbus_en,    // Onboard VBUS enable
    input wire logic       paddle01_vbus_en_n, // Ports 0/1 enable
    input wire logic       paddle24_vbus_en_n, // Ports 2/4 enable
    input wire logic       onboard_vbus_dis,   // Onboard disable
    input wire logic       soft_button_reset,  // Soft reset pulse
    input wire logic [7:0] gpio_pin_oe_n       // GPIO enables
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic [4:0] soft_cnt_reg;
    ////////////////////////////////////////////////////////////////////////
    // Length of the current soft reset pulse
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || !soft_button_reset)
            soft_cnt_reg <= 5'h00;
        else
            soft_cnt_reg <= soft_cnt_reg + 5'h01;
    end
    ////////////////////////////////////////////////////////////////////////
    // Control outputs follow a write two edges later, read data follows a read one edge later
    card_gate_a: assert property (reg_wr && reg_addr == 4'h0 |-> ##2
        card_one_power_en == ($past(s0_power) | !$past(reg_wdata[0], 2)))
        else $error("card one enable wrong");
    keep_out_a: assert property (reg_wr && reg_addr == 4'h0 |-> ##2
        pullup_power_keep_signal == ($past(s0_power) | $past(reg_wdata[1], 2)))
        else $error("pull-up keep wrong");
    wless_out_a: assert property (reg_wr && reg_addr == 4'h1 |-> ##2
        wireless_disable == ($past(wireless_ext) | $past(reg_wdata[6], 2)))
        else $error("wireless disable wrong");
    lan_off_a: assert property (reg_wr && reg_addr == 4'h1 |-> ##2
        lan_off_input_n == !$past(reg_wdata[4], 2))
        else $error("lan off wrong");
    vbus_sw_a: assert property (reg_wr && reg_addr == 4'h1 |-> ##2
        {paddle24_vbus_en_n, paddle01_vbus_en_n, onboard_vbus_dis}
        == $past(reg_wdata[2:0], 2)) else $error("vbus switches wrong");
    vbus_id_a: assert property (reg_wr && reg_addr == 4'h1 |-> ##2
        onboard_vbus_en == (!$past(reg_wdata[0], 2) &&
        (!$past(reg_wdata[3], 2) || $past(usb_id_a_cable))))
        else $error("id vbus wrong");
    dir_drive_a: assert property (reg_wr && reg_addr == 4'h3 && !plat_rst
        ##1 !plat_rst |-> ##1 gpio_pin_oe_n == ~$past(reg_wdata, 2))
        else $error("pin enable wrong");
    status_rd_a: assert property (reg_rd && reg_addr == 4'h2 |=>
        reg_rdata[7:3] == {$past(cpu_thermal_trip), $past(panel_overcurrent),
        {3{$past(paddle_overcurrent)}}} && reg_rdata[1:0] == 2'h0)
        else $error("status read wrong");
    rsvd_zero_a: assert property (reg_rd && reg_addr <= 4'h1 |=>
        (reg_rdata & ($past(reg_addr) == 4'h0 ? 8'hF8 : 8'hA0)) == 8'h00)
        else $error("reserved bit set");
    soft_start_a: assert property (reg_wr && reg_addr == 4'h2 &&
        reg_wdata[2] && !plat_rst |=> ##1 soft_button_reset[*8])
        else $error("soft reset not started");
    soft_len_a: assert property ($fell(soft_button_reset) &&
        !$past(plat_rst) |-> soft_cnt_reg == 5'h10)
        else $error("soft reset length wrong");
endmodule // aon_misc_regs_checker

bind aon_misc_regs aon_misc_regs_checker aon_misc_regs_checker_inst (
    .clk_sys, .sys_rst, .plat_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .s0_power, .wireless_ext, .usb_id_a_cable, .cpu_thermal_trip,
    .panel_overcurrent, .paddle_overcurrent, .card_one_power_en,
    .pullup_power_keep_signal, .wireless_disable, .lan_off_input_n,
    .onboard_vbus_en, .paddle01_vbus_en_n, .paddle24_vbus_en_n,
    .onboard_vbus_dis, .soft_button_reset, .gpio_pin_oe_n);

// file: verification/testbench.sv
// Self-checking testbench for the always-on register bank
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys, sys_rst, plat_rst, reg_wr, reg_rd, s0_power;
    logic       wireless_ext, usb_id_a_cable, cpu_thermal_trip;
    logic       panel_overcurrent, paddle_overcurrent, card_one_power_en;
    logic       card_two_power_en, pullup_power_keep_signal, wireless_disable;
    logic       lan_off_input_n, onboard_vbus_en, paddle01_vbus_en_n;
    logic       paddle24_vbus_en_n, onboard_vbus_dis, soft_button_reset;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, gpio_pin_in, gpio_pin_out, gpio_pin_oe_n;
    logic [7:0] ctl;
    int         miscompares = 0;
    int         compares = 0;
    // Control outputs gathered for one compare
    assign ctl = {card_one_power_en, card_two_power_en, pullup_power_keep_signal,
        wireless_disable, lan_off_input_n, onboard_vbus_en, paddle01_vbus_en_n,
        paddle24_vbus_en_n};
    aon_misc_regs aon_misc_regs_inst (.clk_sys, .sys_rst, .plat_rst, .reg_wr,
        .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .s0_power, .wireless_ext,
        .usb_id_a_cable, .cpu_thermal_trip, .panel_overcurrent,
        .paddle_overcurrent, .card_one_power_en, .card_two_power_en,
        .pullup_power_keep_signal, .wireless_disable, .lan_off_input_n,
        .onboard_vbus_en, .paddle01_vbus_en_n, .paddle24_vbus_en_n,
        .onboard_vbus_dis, .soft_button_reset, .gpio_pin_in, .gpio_pin_out,
        .gpio_pin_oe_n);
    ////////////////////////////////////////////////////////////////////////
    // Shared bus and compare tasks; tick, wr and rdchk return 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        reg_rd = 1'b1;
        reg_addr = a;
        tick(1);
        reg_rd = 1'b0;
        chk($sformatf("offset %0h", a), e, reg_rdata);
        tick(1);
    endtask
    task automatic summarize();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_reset();
        for (int a = 0; a < 6; a++)
            rdchk(4'(a), 8'h00);
        rdchk(4'h6, 8'hA5);
        rdchk(4'hF, 8'h00);
        chk("oe_n", 8'hFF, gpio_pin_oe_n);
        chk("ctl", 8'hCC, ctl);
        $display("done reset values");
    endtask
    task automatic test_control();
        wr(4'h0, 8'hFF);
        rdchk(4'h0, 8'h07);
        chk("ctl sleep", 8'h2C, ctl);
        s0_power = 1'b1;
        tick(2);
        chk("ctl s0", 8'hEC, ctl);
        wr(4'h1, 8'hFF);
        rdchk(4'h1, 8'h5F);
        chk("ctl all off", 8'hF3, ctl);
        chk("onboard dis", 8'h01, {7'h00, onboard_vbus_dis});
        wr(4'h1, 8'h08);
        chk("ctl id b", 8'hE8, ctl);
        usb_id_a_cable = 1'b1;
        tick(2);
        chk("ctl id a", 8'hEC, ctl);
        wr(4'h1, 8'h09);
        chk("ctl id dis", 8'hE8, ctl);
        wr(4'h1, 8'h00);
        wireless_ext = 1'b1;
        tick(2);
        chk("ctl ext", 8'hFC, ctl);
        wireless_ext = 1'b0;
        $display("done control outputs");
    endtask
    task automatic test_status();
        for (int i = 0; i < 3; i++)
        begin
            {cpu_thermal_trip, panel_overcurrent, paddle_overcurrent} = 3'h4 >> i;
            tick(1);
            rdchk(4'h2, i == 2 ? 8'h38 : 8'h80 >> i);
        end
        {cpu_thermal_trip, panel_overcurrent, paddle_overcurrent} = 3'h0;
        $display("done status read");
    endtask
    task automatic test_soft();
        int n;
        n = 0;
        wr(4'h2, 8'hFB);
        chk("no pulse", 8'h00, {7'h00, soft_button_reset});
        rdchk(4'h2, 8'h00);
        // Write inline so the count starts at the edge that takes it
        reg_wr = 1'b1;
        reg_addr = 4'h2;
        reg_wdata = 8'h04;
        tick(1);
        reg_wr = 1'b0;
        for (int k = 0; k < 40 && soft_button_reset === 1'b1; k++)
        begin
            n++;
            tick(1);
        end
        chk("pulse length", 8'h10, 8'(n));
        if (n >= 40)
            summarize();
        $display("done soft reset");
    endtask
    task automatic test_gpio();
        gpio_pin_in = 8'h33;
        wr(4'h3, 8'hF0);
        wr(4'h4, 8'h3C);
        wr(4'h5, 8'h5A);
        rdchk(4'h3, 8'hF0);
        rdchk(4'h4, 8'h3C);
        rdchk(4'h5, 8'h5A);
        chk("oe_n", 8'h0F, gpio_pin_oe_n);
        chk("pin_out", 8'h60, gpio_pin_out & 8'hF0);
        rdchk(4'h6, 8'h33);
        $display("done gpio config");
    endtask
    task automatic test_resets();
        wr(4'h1, 8'h50);
        plat_rst = 1'b1;
        tick(1);
        plat_rst = 1'b0;
        tick(1);
        rdchk(4'h3, 8'hF0);
        rdchk(4'h1, 8'h50);
        wr(4'h0, 8'h05);
        plat_rst = 1'b1;
        tick(1);
        plat_rst = 1'b0;
        tick(1);
        for (int a = 3; a < 6; a++)
            rdchk(4'(a), 8'h00);
        rdchk(4'h0, 8'h05);
        sys_rst = 1'b1;
        tick(2);
        sys_rst = 1'b0;
        tick(1);
        rdchk(4'h0, 8'h00);
        rdchk(4'h1, 8'h00);
        $display("done resets");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Clock, hang limit and main sequence
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial
    begin
        #200000;
        miscompares++;
        summarize();
    end
    initial
    begin
        {sys_rst, plat_rst, reg_wr, reg_rd, s0_power} = 5'h10;
        {wireless_ext, usb_id_a_cable, cpu_thermal_trip} = 3'h0;
        {panel_overcurrent, paddle_overcurrent} = 2'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        gpio_pin_in = 8'hA5;
        tick(16);
        sys_rst = 1'b0;
        tick(1);
        test_reset();
        test_control();
        test_status();
        test_soft();
        test_gpio();
        test_resets();
        summarize();
    end
endmodule // testbench
